// [ioxp_pkg.sv]
// constants and types shared by the 24-bit port expander
`default_nettype none
package ioxp_pkg;
  // ==========================================================
  // port geometry
  localparam int BANKS = 3;           // number of 8-bit banks
  localparam int BANK_W = 8;          // bits per bank
  localparam int PINS = 24;           // port pins in total
  // ==========================================================
  // register index selected by the command byte
  localparam logic [3:0] REG_IN = 4'h0;    // input banks 0..2
  localparam logic [3:0] REG_OUT = 4'h3;   // output banks 0..2
  localparam logic [3:0] REG_POL = 4'h6;   // polarity banks 0..2
  localparam logic [3:0] REG_CFG = 4'h9;   // direction banks 0..2
  localparam logic [3:0] REG_LAST = 4'hB;  // pointer wraps after this
  // ==========================================================
  // reset values, one bank each
  localparam logic [7:0] CFG_RST = 8'hFF;  // all pins inputs
  localparam logic [7:0] OUT_RST = 8'hFF;  // output latch default
  localparam logic [7:0] POL_RST = 8'h00;  // no inversion
  // ==========================================================
  // bus address: upper six bits fixed, lowest bit from the select pin
  localparam logic [5:0] SLAVE_BASE = 6'h11;  // arbitrary value
  // ==========================================================
  // bus rate
  localparam int CLK_KHZ = 40000;     // core clock, 25 ns period
  localparam int SCL_MAX_KHZ = 400;   // fastest bus clock accepted
  localparam int SCL_PERIOD_CLK = CLK_KHZ / SCL_MAX_KHZ;  // cycles
  // ==========================================================
  // protocol states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_CMD = 4'b0011,
    ST_CMD_ACK = 4'b0100,
    ST_WR = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD = 4'b0111,
    ST_RD_ACK = 4'b1000
  } ioxp_state_e;
endpackage
`default_nettype wire

// [ioxp_sync.sv]
// two flip-flop synchroniser for a group of asynchronous levels
`default_nettype none
module ioxp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // two stages, reset to the idle level of each signal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // ioxp_sync
`default_nettype wire

// [ioxp_expander.sv]
// 24-bit port expander: two-wire bus slave, register banks and pins
`default_nettype none
module ioxp_expander (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // external reset pin and address select
  input wire logic rstPinN,
  input wire logic addrSel,
  // two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // port pins
  input wire logic [23:0] portIn,
  output logic [23:0] portOut,
  output logic [23:0] portOe,
  // open-drain interrupt
  output logic intOut,
  output logic intOe
);
  // ==========================================================
  // synchronised inputs
  logic [27:0] syncVec;      // all pins after two flops
  logic rstPinS;             // reset pin, active low
  logic addrS;               // address select
  logic sclS;                // bus clock
  logic sdaS;                // bus data
  logic [23:0] pinS;         // port pin levels
  logic sclPrev_r;           // bus clock one cycle later
  logic sdaPrev_r;           // bus data one cycle later
  logic softRst;             // reset from the pin

  ioxp_sync #(
    .WIDTH(28),
    .RESET_VAL({4'hB, 24'h000000})
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({rstPinN, addrSel, scl, sdaIn, portIn}),
    .dout(syncVec)
  );

  assign {rstPinS, addrS, sclS, sdaS, pinS} = syncVec;
  assign softRst = !rstPinS;

  // ==========================================================
  // edge history for start, stop and clock edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  logic sclRise;   // bus clock rising
  logic sclFall;   // bus clock falling
  logic startCond; // data falls with clock high
  logic stopCond;  // data rises with clock high
  // sampling at 40 MHz leaves ample cycles per 400 kHz half period
  assign sclRise = sclS && !sclPrev_r;
  assign sclFall = !sclS && sclPrev_r;
  assign startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
  assign stopCond = sclS && sclPrev_r && !sdaPrev_r && sdaS;

  // ==========================================================
  // protocol state
  ioxp_pkg::ioxp_state_e state_r;
  logic [3:0] bitCnt_r;      // bits moved in the current byte
  logic [7:0] shift_r;       // received byte
  logic [7:0] txByte_r;      // byte being sent
  logic [3:0] ptr_r;         // selected register
  logic rw_r;                // read requested
  logic ackd_r;              // master acked a read byte
  logic wrStb;               // a data byte is complete
  logic rdLoad;              // a read byte is fetched
  logic addrHit;             // address byte matches ours
  logic [7:0] rdByte;        // read data at the pointer

  assign wrStb = sclFall && state_r == ioxp_pkg::ST_WR && bitCnt_r == 4'h8;
  assign rdLoad = sclFall && ((state_r == ioxp_pkg::ST_ADDR_ACK && rw_r)
                  || (state_r == ioxp_pkg::ST_RD_ACK && ackd_r));
  assign addrHit = shift_r[7:1] == {ioxp_pkg::SLAVE_BASE, addrS};

  // next register, wrapping after the last one
  function automatic logic [3:0] ptrInc(input logic [3:0] p);
    ptrInc = (p == ioxp_pkg::REG_LAST) ? 4'h0 : p + 4'h1;
  endfunction

  // ==========================================================
  // register banks, one generate slice per bank
  logic [23:0] outReg_r;     // output latches
  logic [23:0] polReg_r;     // polarity inversion
  logic [23:0] cfgReg_r;     // direction, 1 = input
  logic [23:0] inSnap_r;     // input state last reported
  logic snapInit_r;          // snapshot taken after reset
  logic [7:0] rdMux [0:11];  // readable bytes by index

  for (genvar b = 0; b < ioxp_pkg::BANKS; b++) begin : g_bank
    // writes land in the bank the pointer selects
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        outReg_r[8*b +: 8] <= ioxp_pkg::OUT_RST;
        polReg_r[8*b +: 8] <= ioxp_pkg::POL_RST;
        cfgReg_r[8*b +: 8] <= ioxp_pkg::CFG_RST;
      end else if (softRst) begin
        outReg_r[8*b +: 8] <= ioxp_pkg::OUT_RST;
        polReg_r[8*b +: 8] <= ioxp_pkg::POL_RST;
        cfgReg_r[8*b +: 8] <= ioxp_pkg::CFG_RST;
      end else if (wrStb) begin
        if (ptr_r == ioxp_pkg::REG_OUT + 4'(b)) begin
          outReg_r[8*b +: 8] <= shift_r;
        end
        if (ptr_r == ioxp_pkg::REG_POL + 4'(b)) begin
          polReg_r[8*b +: 8] <= shift_r;
        end
        if (ptr_r == ioxp_pkg::REG_CFG + 4'(b)) begin
          cfgReg_r[8*b +: 8] <= shift_r;
        end
      end
    end

    // a read of the input bank updates what the interrupt compares to
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        inSnap_r[8*b +: 8] <= 8'h00;
      end else if (softRst || !snapInit_r) begin
        inSnap_r[8*b +: 8] <= pinS[8*b +: 8];
      end else if (rdLoad && ptr_r == ioxp_pkg::REG_IN + 4'(b)) begin
        inSnap_r[8*b +: 8] <= pinS[8*b +: 8];
      end
    end

    // readback: inputs through the inverter, the rest as stored
    assign rdMux[b] = pinS[8*b +: 8] ^ polReg_r[8*b +: 8];
    assign rdMux[b+3] = outReg_r[8*b +: 8];
    assign rdMux[b+6] = polReg_r[8*b +: 8];
    assign rdMux[b+9] = cfgReg_r[8*b +: 8];
  end

  assign rdByte = rdMux[ptr_r];

  // snapshot is caught at the first clock after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snapInit_r <= 1'b0;
    end else begin
      snapInit_r <= !softRst;
    end
  end

  // ==========================================================
  // bus slave: address, command byte, then data bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ioxp_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txByte_r <= 8'h00;
      ptr_r <= 4'h0;
      rw_r <= 1'b0;
      ackd_r <= 1'b0;
      sdaOe <= 1'b0;
    end else if (softRst || stopCond) begin
      state_r <= ioxp_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe <= 1'b0;
      if (softRst) begin
        ptr_r <= 4'h0;
      end
    end else if (startCond) begin
      // repeated start is allowed mid-frame
      state_r <= ioxp_pkg::ST_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe <= 1'b0;
    end else begin
      unique case (state_r)
        ioxp_pkg::ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        ioxp_pkg::ST_ADDR, ioxp_pkg::ST_CMD, ioxp_pkg::ST_WR: begin
          if (sclRise && bitCnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sdaS};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == 4'h8) begin
            bitCnt_r <= 4'h0;
            sdaOe <= 1'b1;  // ack by pulling low
            if (state_r == ioxp_pkg::ST_ADDR) begin
              // a foreign address leaves the bus alone
              state_r <= addrHit ? ioxp_pkg::ST_ADDR_ACK
                                 : ioxp_pkg::ST_IDLE;
              sdaOe <= addrHit;
              rw_r <= shift_r[0];
            end else if (state_r == ioxp_pkg::ST_CMD) begin
              ptr_r <= (shift_r[3:0] > ioxp_pkg::REG_LAST) ? 4'h0
                       : shift_r[3:0];
              state_r <= ioxp_pkg::ST_CMD_ACK;
            end else begin
              ptr_r <= ptrInc(ptr_r);
              state_r <= ioxp_pkg::ST_WR_ACK;
            end
          end
        end
        ioxp_pkg::ST_ADDR_ACK, ioxp_pkg::ST_CMD_ACK,
        ioxp_pkg::ST_WR_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            if (state_r == ioxp_pkg::ST_ADDR_ACK && rw_r) begin
              txByte_r <= rdByte;
              sdaOe <= !rdByte[7];
              ptr_r <= ptrInc(ptr_r);
              state_r <= ioxp_pkg::ST_RD;
            end else if (state_r == ioxp_pkg::ST_ADDR_ACK) begin
              state_r <= ioxp_pkg::ST_CMD;
            end else begin
              state_r <= ioxp_pkg::ST_WR;
            end
          end
        end
        ioxp_pkg::ST_RD: begin
          if (sclFall) begin
            if (bitCnt_r == 4'h7) begin
              bitCnt_r <= 4'h0;
              sdaOe <= 1'b0;
              state_r <= ioxp_pkg::ST_RD_ACK;
            end else begin
              bitCnt_r <= bitCnt_r + 4'h1;
              txByte_r <= {txByte_r[6:0], 1'b0};
              sdaOe <= !txByte_r[6];
            end
          end
        end
        ioxp_pkg::ST_RD_ACK: begin
          if (sclRise) begin
            ackd_r <= !sdaS;
          end else if (sclFall) begin
            if (ackd_r) begin
              txByte_r <= rdByte;
              sdaOe <= !rdByte[7];
              ptr_r <= ptrInc(ptr_r);
              state_r <= ioxp_pkg::ST_RD;
            end else begin
              state_r <= ioxp_pkg::ST_IDLE;  // master ended the read
            end
          end
        end
        default: begin
          state_r <= ioxp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pins and interrupt, all from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portOut <= {3{ioxp_pkg::OUT_RST}};
      portOe <= 24'h000000;
      intOe <= 1'b0;
      intOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      portOut <= outReg_r;
      portOe <= ~cfgReg_r;
      // only input pins take part in the compare
      intOe <= snapInit_r && |((pinS ^ inSnap_r) & cfgReg_r);
      intOut <= 1'b0;
      sdaOut <= 1'b0;  // open drain: low when enabled
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addrDone;
    sclFall && state_r == ioxp_pkg::ST_ADDR && bitCnt_r == 4'h8;
  endsequence

  a_dir_reset: assert property (softRst |-> ##2 portOe == 24'h000000)
    else $error("pins not inputs after reset pin");
  a_dir_write: assert property (wrStb && ptr_r == ioxp_pkg::REG_CFG
    && !softRst |-> ##2 portOe[7:0] == ~$past(shift_r, 2))
    else $error("direction write not applied to pins");
  a_out_hold: assert property (!softRst && !(wrStb
    && ptr_r >= ioxp_pkg::REG_OUT && ptr_r < ioxp_pkg::REG_POL)
    |=> $stable(outReg_r))
    else $error("output latch changed without write");
  a_int_level: assert property (snapInit_r && !softRst
    && |((pinS ^ inSnap_r) & cfgReg_r) |=> intOe)
    else $error("interrupt not asserted on mismatch");
  a_int_clear: assert property (rdLoad && ptr_r == ioxp_pkg::REG_IN
    && !softRst |=> inSnap_r[7:0] == $past(pinS[7:0]))
    else $error("input read did not refresh snapshot");
  a_pol_read: assert property (rdLoad && !softRst && !stopCond
    && !startCond && ptr_r == ioxp_pkg::REG_IN
    |=> txByte_r == $past(pinS[7:0] ^ polReg_r[7:0]))
    else $error("inverted input read wrong");
  // the address match is fused onto the end of the address byte sequence
  a_addr_ack: assert property (s_addrDone ##0 (addrHit
    && !softRst && !stopCond && !startCond)
    |=> state_r == ioxp_pkg::ST_ADDR_ACK && sdaOe)
    else $error("own address not acked");
  a_cmd_then_data: assert property (sclFall
    && state_r == ioxp_pkg::ST_CMD_ACK && !softRst && !stopCond
    && !startCond |=> state_r == ioxp_pkg::ST_WR)
    else $error("command ack not followed by data");
endmodule // ioxp_expander
`default_nettype wire

// [ioxp_master.sv]
// two-wire bus master model driving the expander's bus pins
`default_nettype none
module ioxp_master (
  // data line level on the wire
  input wire logic sdaWire,
  // master drives, open drain on data
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter bus period: 2.5 us period keeps to 400 kHz
  localparam int Q = 625;
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // one bit: data moves only while clock is low, sampled mid-high
  task automatic bitX(input logic b, output logic r);
    sdaLow = ~b;
    #Q scl = 1'b1;
    #Q r = sdaWire;
    #Q scl = 1'b0;
    #Q;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // stop: data rises while clock high, bus left idle
  task automatic stop();
    sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // byte out msb first, ninth bit released for the slave ack
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitX(d[i], r);
    end
    bitX(1'b1, r);
    ack = ~r;
  endtask
  // byte in msb first, then master ack or nack on the last byte
  task automatic readByte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitX(1'b1, r);
      d[i] = r;
    end
    bitX(nack, r);
  endtask
endmodule // ioxp_master
`default_nettype wire

// [ioxp_expander_tb.sv]
// self-checking bench for the 24-bit port expander
`default_nettype none
module ioxp_expander_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rstPinN = 1'b1;
  logic addrSel = 1'b0; // changed only under reset
  logic scl, sdaLow, sdaOut, sdaOe, intOut, intOe, sdaWire;
  logic intWire; // interrupt line behind its pull-up, low = asserted
  logic [23:0] extIn = 24'h000000; // level forced by the board
  logic [23:0] portIn, portOut, portOe;
  logic [7:0] cfgM[3], outM[3], polM[3]; // register model
  int nMismatch = 0;
  int testsRun = 0;
  always #12.5 clk = ~clk;
  // pull-up on data; a driven pin shows its own output level
  assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
  assign intWire = ~(intOe & ~intOut);
  assign portIn = (portOe & portOut) | (~portOe & extIn);
  ioxp_expander dut (.clk(clk), .rst(rst), .rstPinN(rstPinN),
    .addrSel(addrSel), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .portIn(portIn), .portOut(portOut), .portOe(portOe),
    .intOut(intOut), .intOe(intOe));
  ioxp_master m (.sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
  // ==========================================================
  // model and checks
  task automatic check(logic [23:0] got, logic [23:0] exp, string what);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s %h vs %h", $time, what, got, exp);
    end
  endtask
  task automatic resetModel();
    for (int b = 0; b < 3; b++) begin
      cfgM[b] = ioxp_pkg::CFG_RST;
      outM[b] = ioxp_pkg::OUT_RST;
      polM[b] = ioxp_pkg::POL_RST;
    end
  endtask
  // register contents as the model expects them at index k
  function automatic logic [7:0] expReg(int k);
    int b;
    logic [7:0] pin;
    b = k % 3;
    pin = (extIn[8*b+:8] & cfgM[b]) | (outM[b] & ~cfgM[b]);
    case (k / 3)
      0: return pin ^ polM[b];
      1: return outM[b];
      2: return polM[b];
      default: return cfgM[b];
    endcase
  endfunction
  task automatic checkPins(string what);
    check(portOut, {outM[2], outM[1], outM[0]}, what);
    check(portOe, ~{cfgM[2], cfgM[1], cfgM[0]}, what);
  endtask
  // write a run of bytes from index cmd; pointer wraps after 11
  task automatic wr(logic [3:0] cmd, logic [7:0] q[$]);
    logic ack;
    int p;
    p = cmd;
    m.start();
    m.writeByte({ioxp_pkg::SLAVE_BASE, addrSel, 1'b0}, ack);
    check(24'(ack), 24'h1, "address ack");
    m.writeByte({4'h0, cmd}, ack);
    check(24'(ack), 24'h1, "command ack");
    foreach (q[i]) begin
      m.writeByte(q[i], ack);
      check(24'(ack), 24'h1, "data ack");
      case (p / 3)
        1: outM[p % 3] = q[i];
        2: polM[p % 3] = q[i];
        3: cfgM[p % 3] = q[i];
        default: ;
      endcase
      p = (p == 11) ? 0 : p + 1;
    end
    m.stop();
  endtask
  // read n bytes from index cmd through a repeated start
  task automatic rd(logic [3:0] cmd, int n);
    logic ack;
    logic [7:0] d;
    int p;
    p = (cmd > 4'hB) ? 0 : int'(cmd); // out of range selects index 0
    m.start();
    m.writeByte({ioxp_pkg::SLAVE_BASE, addrSel, 1'b0}, ack);
    m.writeByte({4'h0, cmd}, ack);
    m.start();
    m.writeByte({ioxp_pkg::SLAVE_BASE, addrSel, 1'b1}, ack);
    check(24'(ack), 24'h1, "read address ack");
    for (int k = 0; k < n; k++) begin
      m.readByte(k == n - 1, d);
      check(24'(d), 24'(expReg((p + k) % 12)), "read data");
    end
    m.stop();
  endtask
  task automatic intIs(logic v, logic [23:0] flip);
    extIn = extIn ^ flip;
    repeat (8) @(negedge clk);
    check(24'(intWire), 24'(!v), "interrupt line");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: the tests need about 1.9 ms
  initial begin
    #2400000;
    nMismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    logic [7:0] q[$];
    logic ack;
    void'($urandom(43402));
    resetModel();
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    checkPins("reset pins");
    rd(4'h0, 13);
    $display("test defaults done");
    // random output, polarity and direction banks
    for (int i = 0; i < 9; i++) q.push_back(8'($urandom));
    wr(4'h3, q);
    extIn = 24'($urandom);
    repeat (8) @(negedge clk);
    checkPins("random pins");
    rd(4'h0, 12);
    $display("test random registers done");
    // bank 0 low nibble inputs; reading refreshes the snapshot
    q = '{8'h0F};
    wr(4'h9, q);
    rd(4'h0, 3);
    intIs(1'b0, 24'h000040); // output pin is ignored
    // a new level on a driven pin differs from its snapshot, masked out
    q = '{outM[0] ^ 8'h40};
    wr(4'h3, q);
    intIs(1'b0, 24'h000000);
    intIs(1'b1, 24'h000002);
    intIs(1'b0, 24'h000002);
    intIs(1'b1, 24'h000002);
    rd(4'h0, 1);
    intIs(1'b0, 24'h000000);
    $display("test interrupt done");
    // reset pin returns every register to its default
    rstPinN = 1'b0;
    repeat (4) @(negedge clk);
    rstPinN = 1'b1;
    resetModel();
    repeat (6) @(negedge clk);
    checkPins("pin reset");
    rd(4'h3, 9);
    $display("test reset pin done");
    // second power-on reset with the other address selected
    rst = 1'b1;
    addrSel = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    m.start();
    m.writeByte({ioxp_pkg::SLAVE_BASE, 1'b0, 1'b0}, ack);
    check(24'(ack), 24'h0, "foreign address");
    m.stop();
    q = '{8'($urandom), 8'h00};
    wr(4'h3, q);
    repeat (8) @(negedge clk);
    checkPins("second address");
    rd(4'hD, 2);
    $display("test address select done");
    summarize();
  end
endmodule // ioxp_expander_tb
`default_nettype wire
